// ==== design/fdcrs_consts.svh ====
// Constants for the rate select, input register and result status block
// What this block does
// - Third register mode when identity select and recording mode both low.
// - Second mode input register reads bits 3 to 6 as ones.
// - Input bit 7 is inverted disk-change pin, or the forced value.
// - Third mode bits 1:0 show rate; hardware reset sets 250 Kbps code.
// - Third mode bit 2 reads back the stored no-precompensation bit.
// - Third mode bit 3 mirrors output register DMA gate enable.
// - Third mode bits 4 to 6 read zero; bits 2,3 reset zero.
// - Write to 3F7 loads rate select from bits 1:0; not readable.
// - Third mode stores config bit 2, no effect, kept on soft reset.
// - Density output goes high on hardware reset, soft resets leave it.
// - Result phase returns status bytes of the last command.
// - Status 0 bits 7:6 carry the termination code.
// - Status 0 bit 5 set when seek, relative seek or recalibrate ends.
// - Status 0 bit 4 set on 80 steps without track zero, or overstep.
// - Status 0 bit 3 zero, bit 2 head, bits 1:0 drive number.
// - Status 1 bit 7 on access past final sector; bits 6,3 zero.
// - Status 1 bit 5 on CRC error in ID or data field.
// - Status 1 bit 4 on missed host or DMA service.
// - Status 1 bit 2 when sector, ID or sector sequence not found.
// - Status 1 bit 1 when write protect active during a write command.
// - Status 1 bit 0 when no address mark within two index pulses.
`ifndef FDCRS_CONSTS_SVH
`define FDCRS_CONSTS_SVH

`define FDCRS_ADDR_INPUT 16'h03f7
`define FDCRS_ADDR_DATA 16'h03f5
`define FDCRS_RATE_RESET 2'h2
`define FDCRS_PRECOMP_RESET 1'h0
`define FDCRS_DENSITY_RESET 1'h1
`define FDCRS_RECAL_STEPS 7'h50
`define FDCRS_INDEX_LIMIT 2'h2
`define FDCRS_TERM_NORMAL 2'h0
`define FDCRS_BIT_DISKCHG 7
`define FDCRS_BIT_PRECOMP 2
`define FDCRS_BIT_DMAGATE 3
`define FDCRS_MODE2_ONES 4'hf
`define FDCRS_MODE3_ZEROS 3'h0
`define FDCRS_RATE_1M 2'h3
`define FDCRS_RATE_500K 2'h0

`endif

// ==== design/fdcrs_pkg.sv ====
// Types shared by the rate select and result status block
package fdcrs_pkg;
   typedef enum logic [1:0] {
      MODE_FIRST,
      MODE_SECOND,
      MODE_THIRD
   } fdcrs_mode_t;

   typedef enum logic [1:0] {
      RECAL_IDLE,
      RECAL_STEP,
      RECAL_FAIL
   } fdcrs_recal_t;
endpackage

// ==== design/fdcrs_status_if.sv ====
// Carrier from the top-level logic to the status byte encoder
interface fdcrs_status_if;
   logic cmdStart;
   logic softReset;
   logic termValid;
   logic [1:0] termCode;
   logic seekDone;
   logic equipFault;
   logic headAddr;
   logic [1:0] driveNumber;
   logic pastLastSector;
   logic crcFault;
   logic serviceMissed;
   logic sectorNotFound;
   logic writeBlocked;
   logic markMissing;
   logic [7:0] status0;
   logic [7:0] status1;

   modport enc (
      input cmdStart, softReset, termValid, termCode, seekDone, equipFault,
      input headAddr, driveNumber, pastLastSector, crcFault, serviceMissed,
      input sectorNotFound, writeBlocked, markMissing,
      output status0, status1
   );
   modport ctl (
      output cmdStart, softReset, termValid, termCode, seekDone, equipFault,
      output headAddr, driveNumber, pastLastSector, crcFault, serviceMissed,
      output sectorNotFound, writeBlocked, markMissing,
      input status0, status1
   );
endinterface

// ==== design/fdcrs_status_enc.sv ====
// Sticky result status bytes 0 and 1 for the command just executed
`include "fdcrs_consts.svh"
module fdcrs_status_enc
   import fdcrs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstN,
   fdcrs_status_if.enc st
);
   logic [1:0] termCode_q;
   logic headAddr_q;
   logic [1:0] driveNumber_q;
   logic seekDone_q;
   logic equipFault_q;
   logic [4:0] flags_q;
   logic [4:0] flagSet;
   logic clearAll;
   logic [7:0] status0_q;
   logic [7:0] status1_q;

   ////////////////////////////////////////////////////////////////////////
   // Sticky event bits; a set in the clearing cycle survives the clear
   assign clearAll = st.cmdStart | st.softReset;
   assign flagSet = {st.pastLastSector, st.crcFault, st.serviceMissed,
                     st.sectorNotFound | st.writeBlocked, st.markMissing};

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         termCode_q <= `FDCRS_TERM_NORMAL;
         headAddr_q <= 1'h0;
         driveNumber_q <= 2'h0;
         seekDone_q <= 1'h0;
         equipFault_q <= 1'h0;
      end else begin
         if (st.termValid) begin
            termCode_q <= st.termCode;
            headAddr_q <= st.headAddr;
            driveNumber_q <= st.driveNumber;
         end else if (clearAll) begin
            termCode_q <= `FDCRS_TERM_NORMAL;
         end
         seekDone_q <= st.seekDone | (seekDone_q & ~clearAll);
         equipFault_q <= st.equipFault | (equipFault_q & ~clearAll);
      end
   end

   // Not-found and write-protect share no bit; split them out here
   logic notFound_q;
   logic writeBlocked_q;

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         flags_q <= 5'h00;
         notFound_q <= 1'h0;
         writeBlocked_q <= 1'h0;
      end else begin
         flags_q <= flagSet | (flags_q & {5{~clearAll}});
         notFound_q <= st.sectorNotFound | (notFound_q & ~clearAll);
         writeBlocked_q <= st.writeBlocked
                           | (writeBlocked_q & ~clearAll);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Byte assembly, registered for the data register path
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         status0_q <= 8'h00;
         status1_q <= 8'h00;
      end else begin
         status0_q <= {termCode_q, seekDone_q, equipFault_q, 1'h0,
                       headAddr_q, driveNumber_q};
         status1_q <= {flags_q[4], 1'h0, flags_q[3], flags_q[2], 1'h0,
                       notFound_q, writeBlocked_q,
                       flags_q[0]};
      end
   end

   assign st.status0 = status0_q;
   assign st.status1 = status1_q;
endmodule

// ==== design/fdcrs_top.sv ====
// Host port for input/config register at 3F7 and result status bytes
`include "fdcrs_consts.svh"
module fdcrs_top
   import fdcrs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [15:0] ioAddr,
   input wire logic ioRd,
   input wire logic ioWr,
   input wire logic [7:0] hostDataIn,
   output logic [7:0] hostDataOut,
   output logic [7:0] hostDataOeN,
   input wire logic identSel,
   input wire logic recordMode,
   input wire logic [1:0] forceDiskChanged,
   input wire logic diskChangedPin,
   input wire logic dmaGateEnable,
   input wire logic softReset,
   output logic density_select_out,
   output logic [1:0] rateSelect,
   input wire logic resultPhase,
   input wire logic cmdStart,
   input wire logic termValid,
   input wire logic [1:0] termination_code,
   input wire logic seekDone,
   input wire logic headAddr,
   input wire logic [1:0] drive_number,
   input wire logic recalStart,
   input wire logic stepPulse,
   input wire logic track_zero_in,
   input wire logic relSeekPastZero,
   input wire logic pastLastSector,
   input wire logic tcMissing,
   input wire logic crc_fault,
   input wire logic serviceMissed,
   input wire logic sector_not_found,
   input wire logic writeCmdActive,
   input wire logic writeProtectIn,
   input wire logic idSearch,
   input wire logic idMarkFound,
   input wire logic index_in,
   input wire logic dataMarkMissing
);
   logic rstMeta_q;
   logic rstN_q;
   fdcrs_mode_t mode;
   logic selInput;
   logic selData;
   logic ccrWrite;
   logic inputRead;
   logic dataRead;
   logic [1:0] rate_q;
   logic no_precomp_q;
   logic density_q;
   logic densityNext;
   logic diskChangedBit;
   logic [7:0] inputValue;
   logic [7:0] readValue;
   logic [7:0] readOeN;
   logic [7:0] hostDataOut_q;
   logic [7:0] hostDataOeN_q;
   logic rdPrev_q;
   logic rdStart;
   logic resultPtr_q;
   logic ptrSel;
   fdcrs_recal_t recal_q;
   logic [6:0] stepCount_q;
   logic equipFault;
   logic idxPrev_q;
   logic idxRise;
   logic [1:0] idxCount_q;
   logic idTimeout;
   logic idTimeoutSeen_q;
   fdcrs_status_if st ();

   ////////////////////////////////////////////////////////////////////////
   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rstMeta_q <= 1'h0;
         rstN_q <= 1'h0;
      end else begin
         rstMeta_q <= 1'h1;
         rstN_q <= rstMeta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register mode and address decode
   function automatic logic addrHit(input logic [15:0] a,
                                    input logic [15:0] target);
      addrHit = (a == target);
   endfunction

   assign mode = identSel ? MODE_FIRST :
                 (recordMode ? MODE_SECOND : MODE_THIRD);
   assign selInput = addrHit(ioAddr, `FDCRS_ADDR_INPUT);
   assign selData = addrHit(ioAddr, `FDCRS_ADDR_DATA);
   assign ccrWrite = ioWr & selInput;
   assign inputRead = ioRd & selInput;
   assign dataRead = ioRd & selData & resultPhase;
   assign rdStart = ioRd & ~rdPrev_q;

   ////////////////////////////////////////////////////////////////////////
   // Config control register; only a pin reset touches it
   // Density level follows the rate written: high for 1M and 500K
   assign densityNext = (hostDataIn[1:0] == `FDCRS_RATE_1M)
                        | (hostDataIn[1:0] == `FDCRS_RATE_500K);

   always_ff @(posedge clk_sys or negedge rstN_q) begin
      if (!rstN_q) begin
         rate_q <= `FDCRS_RATE_RESET;
         no_precomp_q <= `FDCRS_PRECOMP_RESET;
         density_q <= `FDCRS_DENSITY_RESET;
      end else if (ccrWrite) begin
         rate_q <= hostDataIn[1:0];
         density_q <= densityNext;
         // Upper bits are expected zero from the host, so bit 2 is kept
         // only where it exists
         if (mode == MODE_THIRD) begin
            no_precomp_q <= hostDataIn[`FDCRS_BIT_PRECOMP];
         end
      end
   end

   assign rateSelect = rate_q;
   assign density_select_out = density_q;

   ////////////////////////////////////////////////////////////////////////
   // Input register value per mode
   assign diskChangedBit = forceDiskChanged[1] ? forceDiskChanged[0]
                                               : ~diskChangedPin;

   always_comb begin
      inputValue = 8'h00;
      readOeN = 8'h00;
      case (mode)
         MODE_FIRST: begin
            // Low bits are left undriven in this mode
            inputValue = {diskChangedBit, 7'h00};
            readOeN = 8'h7f;
         end
         MODE_SECOND: begin
            inputValue = {diskChangedBit, `FDCRS_MODE2_ONES, rate_q,
                          ~densityNext_of(rate_q)};
         end
         MODE_THIRD: begin
            inputValue = {diskChangedBit, `FDCRS_MODE3_ZEROS, dmaGateEnable,
                          no_precomp_q, rate_q};
         end
         default: begin
            inputValue = 8'h00;
            readOeN = 8'hff;
         end
      endcase
   end

   function automatic logic densityNext_of(input logic [1:0] r);
      densityNext_of = (r == `FDCRS_RATE_1M) | (r == `FDCRS_RATE_500K);
   endfunction

   // Pointer flips on the first read cycle; undo that while the read
   // is held so the same byte stands for the whole strobe
   assign ptrSel = resultPtr_q ^ (dataRead & ~rdStart);
   assign readValue = inputRead ? inputValue
                    : (ptrSel ? st.status1 : st.status0);

   ////////////////////////////////////////////////////////////////////////
   // Host read data and drive enables, one cycle behind the strobe
   always_ff @(posedge clk_sys or negedge rstN_q) begin
      if (!rstN_q) begin
         hostDataOut_q <= 8'h00;
         hostDataOeN_q <= 8'hff;
         rdPrev_q <= 1'h0;
      end else begin
         rdPrev_q <= ioRd;
         hostDataOut_q <= (inputRead | dataRead) ? readValue : 8'h00;
         hostDataOeN_q <= inputRead ? readOeN
                        : (dataRead ? 8'h00 : 8'hff);
      end
   end

   assign hostDataOut = hostDataOut_q;
   assign hostDataOeN = hostDataOeN_q;

   // Status 0 first, then status 1; a new command restarts the order
   always_ff @(posedge clk_sys or negedge rstN_q) begin
      if (!rstN_q) begin
         resultPtr_q <= 1'h0;
      end else if (cmdStart | softReset) begin
         resultPtr_q <= 1'h0;
      end else if (dataRead & rdStart) begin
         resultPtr_q <= ~resultPtr_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Recalibrate watch: track zero must show within the step budget
   always_ff @(posedge clk_sys or negedge rstN_q) begin
      if (!rstN_q) begin
         recal_q <= RECAL_IDLE;
         stepCount_q <= 7'h00;
      end else if (softReset) begin
         recal_q <= RECAL_IDLE;
         stepCount_q <= 7'h00;
      end else begin
         case (recal_q)
            RECAL_IDLE: begin
               if (recalStart) begin
                  recal_q <= RECAL_STEP;
                  stepCount_q <= 7'h00;
               end
            end
            RECAL_STEP: begin
               if (track_zero_in) begin
                  recal_q <= RECAL_IDLE;
               end else if (stepCount_q == `FDCRS_RECAL_STEPS) begin
                  recal_q <= RECAL_FAIL;
               end else if (stepPulse) begin
                  stepCount_q <= stepCount_q + 7'h01;
               end
            end
            RECAL_FAIL: begin
               recal_q <= RECAL_IDLE;
            end
            default: begin
               recal_q <= RECAL_IDLE;
            end
         endcase
      end
   end

   assign equipFault = (recal_q == RECAL_FAIL) | relSeekPastZero;

   ////////////////////////////////////////////////////////////////////////
   // ID mark search: two index pulses without a mark gives up
   assign idxRise = index_in & ~idxPrev_q;
   assign idTimeout = idSearch & ~idMarkFound & idxRise
                      & (idxCount_q == `FDCRS_INDEX_LIMIT - 2'h1);

   always_ff @(posedge clk_sys or negedge rstN_q) begin
      if (!rstN_q) begin
         idxPrev_q <= 1'h0;
         idxCount_q <= 2'h0;
         idTimeoutSeen_q <= 1'h0;
      end else begin
         idxPrev_q <= index_in;
         if (~idSearch | idMarkFound | softReset) begin
            idxCount_q <= 2'h0;
            idTimeoutSeen_q <= 1'h0;
         end else if (idxRise & ~idTimeoutSeen_q) begin
            idxCount_q <= idxCount_q + 2'h1;
            idTimeoutSeen_q <= idTimeout;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status encoder hookup
   assign st.cmdStart = cmdStart;
   assign st.softReset = softReset;
   assign st.termValid = termValid;
   assign st.termCode = termination_code;
   assign st.seekDone = seekDone;
   assign st.equipFault = equipFault;
   assign st.headAddr = headAddr;
   assign st.driveNumber = drive_number;
   assign st.pastLastSector = pastLastSector | tcMissing;
   assign st.crcFault = crc_fault;
   assign st.serviceMissed = serviceMissed;
   assign st.sectorNotFound = sector_not_found;
   assign st.writeBlocked = writeCmdActive & writeProtectIn;
   assign st.markMissing = (idTimeout & ~idTimeoutSeen_q)
                           | dataMarkMissing;

   fdcrs_status_enc u_enc (
      .clk_sys (clk_sys),
      .rstN (rstN_q),
      .st (st)
   );
endmodule

// ==== verification/fdcrs_top_asserts.sv ====
// Concurrent checks on the host port of the rate select block
`include "fdcrs_consts.svh"
module fdcrs_top_asserts (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [15:0] ioAddr,
   input wire logic ioRd,
   input wire logic ioWr,
   input wire logic [7:0] hostDataIn,
   input wire logic [7:0] hostDataOut,
   input wire logic [7:0] hostDataOeN,
   input wire logic identSel,
   input wire logic recordMode,
   input wire logic [1:0] forceDiskChanged,
   input wire logic diskChangedPin,
   input wire logic dmaGateEnable,
   input wire logic resultPhase,
   input wire logic density_select_out,
   input wire logic [1:0] rateSelect
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   wire cfgWr = ioWr && ioAddr == `FDCRS_ADDR_INPUT;
   wire inRd = ioRd && ioAddr == `FDCRS_ADDR_INPUT;
   wire dataRd = ioRd && ioAddr == `FDCRS_ADDR_DATA && resultPhase;
   wire third = !identSel && !recordMode;
   wire second = !identSel && recordMode;
   wire bit7 = forceDiskChanged[1] ? forceDiskChanged[0] : !diskChangedPin;
   ////////////////////////////////////////////////////////////////////////
   property p_rate_wr;
      cfgWr |=> rateSelect == $past(hostDataIn[1:0]);
   endproperty
   a_rate_wr: assert property (p_rate_wr) else $error("rate not loaded");
   property p_dens_wr;
      cfgWr |=> density_select_out == ($past(hostDataIn[1:0]) inside {2'h0, 2'h3});
   endproperty
   a_dens_wr: assert property (p_dens_wr) else $error("density wrong");
   // Soft reset is not in the antecedent: it must leave both alone
   property p_hold;
      !cfgWr |=> $stable(rateSelect) && $stable(density_select_out);
   endproperty
   a_hold: assert property (p_hold) else $error("rate or density moved");
   property p_third;
      inRd && third ##1 inRd && third |-> hostDataOeN == 8'h00
         && hostDataOut[6:4] == 3'h0 && hostDataOut[7] == $past(bit7)
         && hostDataOut[3] == $past(dmaGateEnable)
         && hostDataOut[1:0] == rateSelect;
   endproperty
   a_third: assert property (p_third) else $error("third mode read");
   property p_second;
      inRd && second ##1 inRd && second |-> hostDataOut[6:3] == 4'hf;
   endproperty
   a_second: assert property (p_second) else $error("second mode read");
   property p_first;
      inRd && identSel ##1 inRd && identSel |-> hostDataOeN == 8'h7f;
   endproperty
   a_first: assert property (p_first) else $error("first mode enables");
   property p_status;
      dataRd ##1 dataRd |-> hostDataOut[3] == 1'b0 && hostDataOeN == 8'h00;
   endproperty
   a_status: assert property (p_status) else $error("status read");
   property p_idle;
      !ioRd ##1 !ioRd |-> hostDataOut == 8'h00 && hostDataOeN == 8'hff;
   endproperty
   a_idle: assert property (p_idle) else $error("bus not released");
   c_cfg: cover property (cfgWr);
   c_third: cover property (inRd && third ##1 inRd);
   c_data: cover property (dataRd ##1 dataRd);
endmodule

bind fdcrs_top fdcrs_top_asserts fdcrs_top_asserts_i (.clk_sys(clk_sys),
   .resetn(resetn), .ioAddr(ioAddr), .ioRd(ioRd), .ioWr(ioWr),
   .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
   .hostDataOeN(hostDataOeN), .identSel(identSel), .recordMode(recordMode),
   .forceDiskChanged(forceDiskChanged), .diskChangedPin(diskChangedPin),
   .dmaGateEnable(dmaGateEnable), .resultPhase(resultPhase),
   .density_select_out(density_select_out), .rateSelect(rateSelect));

// ==== verification/fdcrs_drive_model.sv ====
// Floppy drive model: index pulses while spinning, cable level pins
module fdcrs_drive_model (
   input wire logic clk_sys,
   input wire logic spin,
   input wire logic atZero,
   input wire logic protect,
   input wire logic changed,
   output logic index_in,
   output logic track_zero_in,
   output logic writeProtectIn,
   output logic diskChangedPin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] revCnt_q = 5'h00;
   // Revolution shortened to 32 cycles to keep the run brief
   always_ff @(posedge clk_sys) begin
      revCnt_q <= spin ? revCnt_q + 5'h01 : 5'h00;
   end
   assign index_in = spin && revCnt_q < 5'h02;
   assign track_zero_in = atZero;
   assign writeProtectIn = protect;
   assign diskChangedPin = changed;
endmodule

// ==== verification/tb_fdcrs_top.sv ====
// Self-checking bench for the rate select and result status block
`include "fdcrs_consts.svh"
module tb_fdcrs_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, resetn = 1'b0, ioRd = 1'b0, ioWr = 1'b0;
   logic [15:0] ioAddr = 16'h0000;
   logic [7:0] hostDataIn = 8'h00, hostDataOut, hostDataOeN, rv;
   logic identSel = 1'b0, recordMode = 1'b0, dmaGateEnable = 1'b0;
   logic [1:0] forceDiskChanged = 2'h0, termination_code = 2'h0;
   logic [1:0] drive_number = 2'h0, rateSelect;
   logic softReset = 1'b0, resultPhase = 1'b0, cmdStart = 1'b0;
   logic termValid = 1'b0, seekDone = 1'b0, headAddr = 1'b0;
   logic recalStart = 1'b0, stepPulse = 1'b0, relSeekPastZero = 1'b0;
   logic pastLastSector = 1'b0, tcMissing = 1'b0, crc_fault = 1'b0;
   logic serviceMissed = 1'b0, sector_not_found = 1'b0, idSearch = 1'b0;
   logic writeCmdActive = 1'b0, idMarkFound = 1'b0, dataMarkMissing = 1'b0;
   logic spin = 1'b0, atZero = 1'b0, protect = 1'b0, changed = 1'b0;
   logic density_select_out, diskChangedPin, track_zero_in;
   logic writeProtectIn, index_in;
   int n_fail = 0, compares = 0, cycles = 0;
   fdcrs_top fdcrs_top_i (.clk_sys(clk_sys), .resetn(resetn),
      .ioAddr(ioAddr), .ioRd(ioRd), .ioWr(ioWr), .hostDataIn(hostDataIn),
      .hostDataOut(hostDataOut), .hostDataOeN(hostDataOeN),
      .identSel(identSel), .recordMode(recordMode),
      .forceDiskChanged(forceDiskChanged), .diskChangedPin(diskChangedPin),
      .dmaGateEnable(dmaGateEnable), .softReset(softReset),
      .density_select_out(density_select_out), .rateSelect(rateSelect),
      .resultPhase(resultPhase), .cmdStart(cmdStart), .termValid(termValid),
      .termination_code(termination_code), .seekDone(seekDone),
      .headAddr(headAddr), .drive_number(drive_number),
      .recalStart(recalStart), .stepPulse(stepPulse),
      .track_zero_in(track_zero_in), .relSeekPastZero(relSeekPastZero),
      .pastLastSector(pastLastSector), .tcMissing(tcMissing),
      .crc_fault(crc_fault), .serviceMissed(serviceMissed),
      .sector_not_found(sector_not_found), .writeCmdActive(writeCmdActive),
      .writeProtectIn(writeProtectIn), .idSearch(idSearch),
      .idMarkFound(idMarkFound), .index_in(index_in),
      .dataMarkMissing(dataMarkMissing));
   fdcrs_drive_model fdcrs_drive_model_i (.clk_sys(clk_sys), .spin(spin),
      .atZero(atZero), .protect(protect), .changed(changed),
      .index_in(index_in), .track_zero_in(track_zero_in),
      .writeProtectIn(writeProtectIn), .diskChangedPin(diskChangedPin));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic chk(input string what, input logic [7:0] e, logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] d);
      ioAddr = `FDCRS_ADDR_INPUT;
      hostDataIn = d;
      ioWr = 1'b1;
      tick(1);
      ioWr = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      ioAddr = a;
      ioRd = 1'b1;
      tick(2);
      d = hostDataOut;
      ioRd = 1'b0;
      tick(2);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd(`FDCRS_ADDR_INPUT, rv);
      chk("input reg", 8'h82, rv);
      chk("density", 8'h01, {7'h0, density_select_out});
   endtask
   task automatic t_config();
      wr(8'h05);
      chk("rate", 8'h01, {6'h0, rateSelect});
      softReset = 1'b1;
      tick(2);
      softReset = 1'b0;
      rd(`FDCRS_ADDR_INPUT, rv);
      chk("after soft", 8'h85, rv);
      chk("density", 8'h00, {7'h0, density_select_out});
      wr(8'h03);
      rd(`FDCRS_ADDR_INPUT, rv);
      chk("input reg", 8'h83, rv);
   endtask
   task automatic t_pins();
      for (int i = 0; i < 8; i++) begin
         changed = i[0];
         forceDiskChanged = i[2:1];
         dmaGateEnable = i[0] ^ i[1];
         rd(`FDCRS_ADDR_INPUT, rv);
         chk("pins", {i[2] ? i[1] : !i[0], 3'h0, i[0] ^ i[1], 3'h3}, rv);
      end
      {changed, forceDiskChanged, dmaGateEnable} = 4'h0;
   endtask
   task automatic t_modes();
      recordMode = 1'b1;
      wr(8'h00);
      rd(`FDCRS_ADDR_INPUT, rv);
      chk("second mode", 8'hf8, rv);
      identSel = 1'b1;
      rd(`FDCRS_ADDR_INPUT, rv);
      chk("first mode", 8'h80, rv & 8'h80);
      {identSel, recordMode} = 2'h0;
   endtask
   task automatic t_hwreset();
      wr(8'h05);
      resetn = 1'b0;
      tick(2);
      resetn = 1'b1;
      tick(3);
      rd(`FDCRS_ADDR_INPUT, rv);
      chk("hw reset input", 8'h82, rv);
      chk("hw reset density", 8'h01, {7'h0, density_select_out});
   endtask
   task automatic t_status(input logic [1:0] code, input logic alt);
      logic [7:0] s0, s1, s2;
      cmdStart = 1'b1;
      tick(1);
      cmdStart = 1'b0;
      {relSeekPastZero, tcMissing, dataMarkMissing} = {3{alt}};
      {seekDone, pastLastSector, crc_fault, protect} = {4{!alt}};
      {serviceMissed, sector_not_found, writeCmdActive} = {3{!alt}};
      tick(1);
      {relSeekPastZero, tcMissing, dataMarkMissing} = 3'h0;
      {seekDone, pastLastSector, crc_fault, protect} = 4'h0;
      {serviceMissed, sector_not_found, writeCmdActive} = 3'h0;
      {termination_code, headAddr, drive_number} = {code, code[0], ~code};
      termValid = 1'b1;
      tick(1);
      termValid = 1'b0;
      tick(3);
      resultPhase = 1'b1;
      rd(`FDCRS_ADDR_DATA, s0);
      rd(`FDCRS_ADDR_DATA, s1);
      rd(`FDCRS_ADDR_DATA, s2);
      resultPhase = 1'b0;
      chk("status0", {code, !alt, alt, 1'b0, code[0], ~code}, s0);
      chk("status1", alt ? 8'h81 : 8'hb6, s1);
      chk("status0 again", s0, s2);
   endtask
   task automatic t_recal();
      logic [7:0] s0, s1;
      cmdStart = 1'b1;
      tick(1);
      {cmdStart, recalStart} = 2'h1;
      tick(1);
      recalStart = 1'b0;
      repeat (80) begin
         stepPulse = 1'b1;
         tick(1);
         stepPulse = 1'b0;
         tick(1);
      end
      {idSearch, spin} = 2'h3;
      tick(70);
      {idSearch, spin} = 2'h0;
      {termination_code, headAddr, drive_number} = 5'h08;
      termValid = 1'b1;
      tick(1);
      termValid = 1'b0;
      tick(3);
      resultPhase = 1'b1;
      rd(`FDCRS_ADDR_DATA, s0);
      rd(`FDCRS_ADDR_DATA, s1);
      resultPhase = 1'b0;
      chk("recal status0", 8'h50, s0);
      chk("mark status1", 8'h01, s1);
   endtask
   initial begin
      tick(10);
      resetn = 1'b1;
      tick(3);
      t_reset();
      t_config();
      t_pins();
      t_modes();
      t_hwreset();
      for (int i = 0; i < 4; i++) t_status(i[1:0], 1'b0);
      t_status(2'h1, 1'b1);
      t_recal();
      complete_run();
   end
endmodule
